// ===== common/ehm_pkg.sv
package ehm_pkg;

    // parameter addresses
    localparam logic [15:0] ADDR_POWER_ON  = 16'h3b04;
    localparam logic [15:0] ADDR_CLEAR     = 16'h3b08;
    localparam logic [15:0] ADDR_REWIND    = 16'h3b0a;
    localparam logic [15:0] ADDR_ERR_NUM   = 16'h3c02;
    localparam logic [15:0] ADDR_CLASS     = 16'h3c04;
    localparam logic [15:0] ADDR_SPEED     = 16'h3c10;
    localparam logic [15:0] ADDR_CURRENT   = 16'h3c12;

    // command value that triggers clear and rewind
    localparam logic [31:0] CMD_TRIGGER    = 32'h0000_0001;

    // history geometry
    localparam int          DEPTH          = 16;
    localparam int          PTR_W          = 4;
    localparam int          CNT_W          = 5;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;
    localparam logic [PTR_W-1:0] PTR_LAST  = 4'hf;

    // error classes
    localparam logic [2:0]  CLASS_WARNING  = 3'h0;
    localparam logic [2:0]  CLASS_QSTOP_A  = 3'h1;
    localparam logic [2:0]  CLASS_QSTOP_B  = 3'h2;
    localparam logic [2:0]  CLASS_FATAL_AK = 3'h3;
    localparam logic [2:0]  CLASS_FATAL_NA = 3'h4;

    localparam logic [31:0] POWER_ON_MAX   = 32'hffff_ffff;
    localparam logic [31:0] POWER_ON_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [15:0] number;
        logic [15:0] err_class;
        logic [15:0] speed;
        logic [15:0] current;
    } ehm_entry_t;

    localparam ehm_entry_t ENTRY_EMPTY = 64'h0000_0000_0000_0000;

endpackage

// ===== common/ehm_hist_if.sv
interface ehm_hist_if;
    import ehm_pkg::*;

    logic                   append;
    ehm_entry_t             new_entry;
    logic                   clear_start;
    logic                   clear_busy;
    logic                   rewind;
    logic                   advance;
    ehm_entry_t             rd_entry;
    logic [CNT_W-1:0]       count;

    modport ctrl (
        output append,
        output new_entry,
        output clear_start,
        output rewind,
        output advance,
        input  clear_busy,
        input  rd_entry,
        input  count
    );

    modport store (
        input  append,
        input  new_entry,
        input  clear_start,
        input  rewind,
        input  advance,
        output clear_busy,
        output rd_entry,
        output count
    );
endinterface

// ===== rtl/ehm_history.sv
module ehm_history (
    input wire logic clk,
    input wire logic resetn,
    ehm_hist_if.store h
);
    import ehm_pkg::*;

    ehm_entry_t             mem [DEPTH];
    logic [PTR_W-1:0]       wr_ptr_reg;
    logic [PTR_W-1:0]       clr_idx_reg;
    logic [PTR_W-1:0]       oldest;
    logic [PTR_W-1:0]       rd_idx;
    logic [CNT_W-1:0]       count_reg;
    logic [CNT_W-1:0]       rd_off_reg;
    logic [CNT_W-1:0]       rd_off_next;
    logic                   busy_reg;
    logic                   full;
    logic                   accept;

    ////////////////////////////////////////////////////////////////////////////////
    assign full         = (count_reg == DEPTH_CNT);
    assign accept       = h.append & ~busy_reg;
    assign oldest       = wr_ptr_reg - count_reg[PTR_W-1:0];
    assign rd_idx       = oldest + rd_off_reg[PTR_W-1:0];
    assign h.rd_entry   = (rd_off_reg < count_reg) ? mem[rd_idx] : ENTRY_EMPTY;
    assign h.count      = count_reg;
    assign h.clear_busy = busy_reg;

    always_ff @(posedge clk) begin
        if (busy_reg) begin
            mem[clr_idx_reg] <= ENTRY_EMPTY;
        end else if (accept) begin
            mem[wr_ptr_reg] <= h.new_entry;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_reg    <= 1'b0;
            clr_idx_reg <= '0;
        end else if (h.clear_start) begin
            busy_reg    <= 1'b1;
            clr_idx_reg <= '0;
        end else if (busy_reg) begin
            busy_reg    <= (clr_idx_reg != PTR_LAST);
            clr_idx_reg <= clr_idx_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (h.clear_start) begin
            wr_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (accept) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (!full) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    always_comb begin
        rd_off_next = rd_off_reg;
        if (h.clear_start || h.rewind) begin
            rd_off_next = '0;
        end else begin
            if (h.advance && (rd_off_reg < count_reg)) begin
                rd_off_next = rd_off_reg + 1'b1;
            end
            if (accept && full && (rd_off_next != '0)) begin
                rd_off_next = rd_off_next - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_off_reg <= '0;
        end else begin
            rd_off_reg <= rd_off_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_advance;
        @(posedge clk) disable iff (!resetn)
        (h.advance && !h.clear_start && !h.rewind && !(accept && full)
         && (rd_off_reg < count_reg)) |=> (rd_off_reg == $past(rd_off_reg) + 1'b1);
    endproperty
    a_advance: assert property (p_advance) else $error("read pointer did not step");

    property p_rewind;
        @(posedge clk) disable iff (!resetn)
        (h.rewind && !h.clear_start) |=> (rd_off_reg == '0) && (rd_idx == oldest);
    endproperty
    a_rewind: assert property (p_rewind) else $error("rewind missed oldest entry");

    property p_append;
        @(posedge clk) disable iff (!resetn)
        (accept && !full && !h.clear_start) |=>
            (count_reg == $past(count_reg) + 1'b1)
            && (mem[$past(wr_ptr_reg)] == $past(h.new_entry));
    endproperty
    a_append: assert property (p_append) else $error("error entry not appended");

    sequence s_erase_walk;
        busy_reg [*8] ##1 busy_reg [*8] ##1 !busy_reg;
    endsequence

    property p_erase;
        @(posedge clk) disable iff (!resetn)
        (h.clear_start && !busy_reg) |=> s_erase_walk;
    endproperty
    a_erase: assert property (p_erase) else $error("erase walk length wrong");

endmodule

// ===== rtl/ehm_top.sv
// Behaviour
// - class read-only, coded 0 to 4
// - writing 1 to clear erases all entries
// - clear reads 0 when erase finished
// - error number read snapshots whole entry
// - error number read advances read pointer
// - writing 1 to rewind points at oldest
// - current captured unsigned 16-bit, 10 mA steps
// - read-only 32-bit power-on cycle count
module ehm_top (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [15:0] par_addr,
    input  wire logic        par_wr,
    input  wire logic        par_rd,
    input  wire logic [31:0] par_wdata,
    output      logic [31:0] par_rdata,
    output      logic        par_ack,
    output      logic        par_err,
    input  wire logic        err_valid,
    input  wire logic [2:0]  err_class,
    input  wire logic [15:0] err_number,
    input  wire logic [15:0] err_speed,
    input  wire logic [15:0] err_current,
    input  wire logic        power_on_pulse,
    output      logic        append_dropped
);
    import ehm_pkg::*;

    ehm_hist_if h ();

    ehm_entry_t             snap_reg;
    logic [31:0]            power_on_reg;
    logic [31:0]            rdata_reg;
    logic [31:0]            rdata_next;
    logic                   ack_reg;
    logic                   err_reg;
    logic                   err_next;
    logic                   dropped_reg;
    logic                   wr_req;
    logic                   rd_req;
    logic                   rd_num;
    logic [2:0]             class_sat;

    ////////////////////////////////////////////////////////////////////////////////
    // history store
    ehm_history u_history (
        .clk    (clk),
        .resetn (resetn),
        .h      (h.store)
    );

    assign wr_req = par_wr;
    assign rd_req = par_rd & ~par_wr;
    assign rd_num = rd_req & (par_addr == ADDR_ERR_NUM);

    ////////////////////////////////////////////////////////////////////////////////
    // error capture
    // clamp class code
    assign class_sat = (err_class > CLASS_FATAL_NA) ? CLASS_FATAL_NA : err_class;

    assign h.append              = err_valid;
    assign h.new_entry.number    = err_number;
    assign h.new_entry.err_class = {13'h0000, class_sat};
    assign h.new_entry.speed     = err_speed;
    assign h.new_entry.current   = err_current;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dropped_reg <= 1'b0;
        end else begin
            dropped_reg <= err_valid & (h.clear_busy | h.clear_start);
        end
    end
    assign append_dropped = dropped_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // commands
    // clear command
    assign h.clear_start = wr_req & (par_addr == ADDR_CLEAR) & (par_wdata == CMD_TRIGGER);
    assign h.rewind      = wr_req & (par_addr == ADDR_REWIND) & (par_wdata == CMD_TRIGGER);
    assign h.advance     = rd_num;

    ////////////////////////////////////////////////////////////////////////////////
    // power-on cycle counter
    // saturating count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            power_on_reg <= POWER_ON_RESET;
        end else if (power_on_pulse && (power_on_reg != POWER_ON_MAX)) begin
            power_on_reg <= power_on_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // snapshot buffer
    // copy entry on number read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            snap_reg <= ENTRY_EMPTY;
        end else if (rd_num) begin
            snap_reg <= h.rd_entry;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // parameter access
    always_comb begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        if (wr_req) begin
            unique case (par_addr)
                ADDR_CLEAR, ADDR_REWIND: err_next = 1'b0;
                default:                 err_next = 1'b1;
            endcase
        end else if (rd_req) begin
            unique case (par_addr)
                ADDR_POWER_ON: rdata_next = power_on_reg;
                ADDR_CLEAR:    rdata_next = {31'h0000_0000, h.clear_busy};
                ADDR_REWIND:   rdata_next = 32'h0000_0000;
                ADDR_ERR_NUM:  rdata_next = {16'h0000, h.rd_entry.number};
                ADDR_CLASS:    rdata_next = {16'h0000, snap_reg.err_class};
                ADDR_SPEED:    rdata_next = {16'h0000, snap_reg.speed};
                ADDR_CURRENT:  rdata_next = {16'h0000, snap_reg.current};
                default:       err_next   = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h0000_0000;
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg   <= wr_req | rd_req;
            err_reg   <= err_next;
        end
    end

    assign par_rdata = rdata_reg;
    assign par_ack   = ack_reg;
    assign par_err   = err_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_class_range;
        @(posedge clk) disable iff (!resetn)
        (rd_req && par_addr == ADDR_CLASS) |=> (par_rdata <= 32'h0000_0004) && par_ack;
    endproperty
    a_class_range: assert property (p_class_range) else $error("class out of range");

    sequence s_clear_req;
        wr_req && (par_addr == ADDR_CLEAR) && (par_wdata == CMD_TRIGGER);
    endsequence

    property p_clear_start;
        @(posedge clk) disable iff (!resetn)
        s_clear_req |=> h.clear_busy && (h.count == '0) ##15 h.clear_busy ##1 !h.clear_busy;
    endproperty
    a_clear_start: assert property (p_clear_start) else $error("clear did not erase");

    property p_clear_read;
        @(posedge clk) disable iff (!resetn)
        (rd_req && par_addr == ADDR_CLEAR) |=> (par_rdata[0] == $past(h.clear_busy));
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("clear status wrong");

    property p_snapshot;
        @(posedge clk) disable iff (!resetn)
        rd_num |=> (snap_reg == $past(h.rd_entry))
                   && (par_rdata[15:0] == snap_reg.number) && par_ack;
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

    property p_current;
        @(posedge clk) disable iff (!resetn)
        (rd_req && par_addr == ADDR_CURRENT) |=> (par_rdata == {16'h0000, snap_reg.current});
    endproperty
    a_current: assert property (p_current) else $error("current read wrong");

    property p_power;
        @(posedge clk) disable iff (!resetn)
        (power_on_pulse && power_on_reg != POWER_ON_MAX) |=>
            (power_on_reg == $past(power_on_reg) + 1'b1);
    endproperty
    a_power: assert property (p_power) else $error("power-on count not stepped");

    property p_class_store;
        @(posedge clk) disable iff (!resetn)
        h.append |-> (h.new_entry.err_class <= {13'h0000, CLASS_FATAL_NA})
                     && (h.new_entry.number == err_number);
    endproperty
    a_class_store: assert property (p_class_store) else $error("stored class illegal");

    property p_ro_write;
        @(posedge clk) disable iff (!resetn)
        (wr_req && par_addr == ADDR_POWER_ON) |=> par_ack && par_err;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("counter write not refused");

    property p_rewind_read;
        @(posedge clk) disable iff (!resetn)
        (rd_req && par_addr == ADDR_REWIND) |=>
            par_ack && !par_err && (par_rdata == 32'h0000_0000);
    endproperty
    a_rewind_read: assert property (p_rewind_read) else $error("rewind read not zero");

    property p_clear_done;
        @(posedge clk) disable iff (!resetn)
        (rd_req && par_addr == ADDR_CLEAR && !h.clear_busy) |=>
            par_ack && (par_rdata == 32'h0000_0000);
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("idle clear not zero");

    property p_dropped;
        @(posedge clk) disable iff (!resetn)
        (err_valid && (h.clear_busy || h.clear_start)) |=> append_dropped;
    endproperty
    a_dropped: assert property (p_dropped) else $error("dropped error not flagged");

endmodule

// ===== test/ehm_master_model.sv
module ehm_master_model (
    input  wire logic        clk,
    output      logic [15:0] par_addr,
    output      logic        par_wr,
    output      logic        par_rd,
    output      logic [31:0] par_wdata,
    input  wire logic [31:0] par_rdata,
    input  wire logic        par_ack,
    input  wire logic        par_err
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        par_addr  = 16'h0000;
        par_wr    = 1'b0;
        par_rd    = 1'b0;
        par_wdata = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // one access: one-cycle request, answer sampled one cycle later
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic k);
        @(posedge clk);
        par_wr    <= w;
        par_rd    <= ~w;
        par_addr  <= a;
        par_wdata <= d;
        @(posedge clk);
        par_wr    <= 1'b0;
        par_rd    <= 1'b0;
        // released lines carry junk, not the last value
        par_addr  <= ~a;
        par_wdata <= ~d;
        #1;
        q = par_rdata;
        e = par_err;
        k = par_ack;
    endtask
endmodule

// ===== test/error_history_memory_tb.sv
module error_history_memory_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ehm_pkg::*;

    logic        clk;
    logic        resetn;
    logic [15:0] par_addr;
    logic        par_wr;
    logic        par_rd;
    logic [31:0] par_wdata;
    logic [31:0] par_rdata;
    logic        par_ack;
    logic        par_err;
    logic        err_valid;
    logic [2:0]  err_class;
    logic [15:0] err_number;
    logic [15:0] err_speed;
    logic [15:0] err_current;
    logic        power_on_pulse;
    logic        append_dropped;
    logic [31:0] q;
    logic        e;
    logic        k;
    logic [2:0]  cl;
    int          err_total;
    int          checks_done;

    ehm_top dut (.clk(clk), .resetn(resetn), .par_addr(par_addr), .par_wr(par_wr),
        .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
        .par_err(par_err), .err_valid(err_valid), .err_class(err_class),
        .err_number(err_number), .err_speed(err_speed), .err_current(err_current),
        .power_on_pulse(power_on_pulse), .append_dropped(append_dropped));

    ehm_master_model mst (.clk(clk), .par_addr(par_addr), .par_wr(par_wr),
        .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata),
        .par_ack(par_ack), .par_err(par_err));

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic ex_err);
        mst.xfer(1'b0, a, 32'h0000_0000, q, e, k);
        chk({30'h0000_0000, k, e}, {30'h0000_0000, 1'b1, ex_err});
        chk(q, exp);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ex_err);
        mst.xfer(1'b1, a, d, q, e, k);
        chk({30'h0000_0000, k, e}, {30'h0000_0000, 1'b1, ex_err});
    endtask

    task automatic add_err(input logic [2:0] c, input logic [15:0] n, input logic drop);
        @(posedge clk);
        err_valid   <= 1'b1;
        err_class   <= c;
        err_number  <= n;
        err_speed   <= ~n;
        err_current <= n + 16'h8000;
        @(posedge clk);
        err_valid   <= 1'b0;
        err_number  <= ~n;
        #1;
        chk({31'h0000_0000, append_dropped}, {31'h0000_0000, drop});
    endtask

    task automatic rd_entry(input logic [15:0] n, input logic [2:0] c);
        rd(ADDR_ERR_NUM, {16'h0000, n}, 1'b0);
        rd(ADDR_CLASS, {29'h0000_0000, c}, 1'b0);
        rd(ADDR_SPEED, {16'h0000, ~n}, 1'b0);
        rd(ADDR_CURRENT, {16'h0000, n + 16'h8000}, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        resetn         = 1'b0;
        err_valid      = 1'b0;
        err_class      = 3'h0;
        err_number     = 16'h0000;
        err_speed      = 16'h0000;
        err_current    = 16'h0000;
        power_on_pulse = 1'b0;
        err_total      = 0;
        checks_done    = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        // power-on counter, read only, unmapped address
        rd(ADDR_POWER_ON, 32'h0000_0000, 1'b0);
        repeat (3) begin
            @(posedge clk);
            power_on_pulse <= 1'b1;
            @(posedge clk);
            power_on_pulse <= 1'b0;
        end
        rd(ADDR_POWER_ON, 32'h0000_0003, 1'b0);
        wr(ADDR_POWER_ON, 32'h0000_0005, 1'b1);
        rd(ADDR_POWER_ON, 32'h0000_0003, 1'b0);
        rd(16'h3b06, 32'h0000_0000, 1'b1);
        // every class code, then walk in order
        for (int i = 0; i < 8; i++) add_err(i[2:0], 16'h0a00 + i[15:0], 1'b0);
        wr(ADDR_CLASS, 32'h0000_0001, 1'b1);
        wr(ADDR_REWIND, 32'h0000_0001, 1'b0);
        for (int i = 0; i < 8; i++) begin
            cl = (i > 4) ? 3'h4 : i[2:0];
            rd_entry(16'h0a00 + i[15:0], cl);
        end
        rd(ADDR_ERR_NUM, 32'h0000_0000, 1'b0);
        // rewind, and a non-trigger value does nothing
        wr(ADDR_REWIND, 32'h0000_0001, 1'b0);
        rd_entry(16'h0a00, 3'h0);
        wr(ADDR_REWIND, 32'h0000_0002, 1'b0);
        rd_entry(16'h0a01, 3'h1);
        // overfill: oldest two overwritten
        for (int i = 8; i < 18; i++) add_err(i[2:0], 16'h0a00 + i[15:0], 1'b0);
        wr(ADDR_REWIND, 32'h0000_0001, 1'b0);
        rd_entry(16'h0a02, 3'h2);
        rd(ADDR_REWIND, 32'h0000_0000, 1'b0);
        // non-trigger clear leaves history intact
        wr(ADDR_CLEAR, 32'h0000_0002, 1'b0);
        rd(ADDR_CLEAR, 32'h0000_0000, 1'b0);
        rd_entry(16'h0a03, 3'h3);
        // clear, busy readback, dropped append, wait for 0
        wr(ADDR_CLEAR, 32'h0000_0001, 1'b0);
        rd(ADDR_CLEAR, 32'h0000_0001, 1'b0);
        add_err(3'h1, 16'h0bbb, 1'b1);
        for (int i = 0; i < 40 && q !== 32'h0000_0000; i++) begin
            mst.xfer(1'b0, ADDR_CLEAR, 32'h0000_0000, q, e, k);
        end
        chk(q, 32'h0000_0000);
        wr(ADDR_REWIND, 32'h0000_0001, 1'b0);
        rd(ADDR_ERR_NUM, 32'h0000_0000, 1'b0);
        add_err(3'h3, 16'h0c00, 1'b0);
        wr(ADDR_REWIND, 32'h0000_0001, 1'b0);
        rd_entry(16'h0c00, 3'h3);
        // mid-run reset empties history and counter
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(ADDR_POWER_ON, 32'h0000_0000, 1'b0);
        rd(ADDR_ERR_NUM, 32'h0000_0000, 1'b0);
        print_verdict();
    end
endmodule
